//--- pkg/fph_pkg.sv
package fph_pkg;
  // Array address width.
  localparam int ADDR_W = 21;
  // Byte offset width inside one page.
  localparam int PAGE_SHIFT = 8;
  // Erase region shifts.
  localparam int SECTOR_SHIFT = 12;
  localparam int BLK32_SHIFT = 15;
  localparam int BLK64_SHIFT = 16;
  // Bytes in one page.
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  // Last opcode and address bit positions.
  localparam logic [4:0] HDR_OPC_LAST = 5'h07;
  localparam logic [4:0] HDR_ADDR_LAST = 5'h1F;
  // Byte end position and step per edge.
  localparam logic [2:0] BIT_LAST_SINGLE = 3'h7;
  localparam logic [2:0] BIT_LAST_QUAD = 3'h4;
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;
  // Synchroniser slots; pins idle high.
  localparam int SYNC_W = 6;
  localparam int SYNC_CS = 0;
  localparam int SYNC_SCK = 1;
  localparam int SYNC_L0 = 2;
  localparam logic [5:0] SYNC_IDLE = 6'h3F;
  // Opcodes handled by this front end.
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;

  // Erase granularity.
  typedef enum logic [1:0] {
    ERASE_SECTOR = 2'h0,
    ERASE_BLK32 = 2'h1,
    ERASE_BLK64 = 2'h2,
    ERASE_CHIP = 2'h3
  } fph_erase_t;

  // Frame phases, Gray coded along idle, opcode, address, data.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b011,
    ST_DATA = 3'b010,
    ST_SKIP = 3'b110
  } fph_state_t;

  // Maps an erase opcode to its granularity.
  function automatic fph_erase_t erase_kind(input logic [7:0] op);
    if (op == OP_SECTOR_ERASE) return ERASE_SECTOR;
    else if (op == OP_BLK32_ERASE) return ERASE_BLK32;
    else if (op == OP_BLK64_ERASE) return ERASE_BLK64;
    else return ERASE_CHIP;
  endfunction
endpackage

//--- rtl/fph_pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a bit changes once stages two and three agree.
module fph_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] din_i,
  output logic [W-1:0] dout_o
);
  logic [W-1:0] s1_ff; // First stage, read only by the second.
  logic [W-1:0] s2_ff; // Second stage.
  logic [W-1:0] s3_ff; // Third stage.

  // Shift chain; the agreement filter rejects single-cycle glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= IDLE;
      s2_ff <= IDLE;
      s3_ff <= IDLE;
      dout_o <= IDLE;
    end else begin
      s1_ff <= din_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout_o <= (s2_ff & s3_ff) | (dout_o & (s2_ff | s3_ff));
    end
  end
endmodule

//--- rtl/fph_erase_map.sv
`timescale 1ns/1ps
// Erase region base and number of an address.
module fph_erase_map (
  input wire fph_pkg::fph_erase_t kind_i,
  input wire logic [fph_pkg::ADDR_W-1:0] addr_i,
  output logic [fph_pkg::ADDR_W-1:0] base_o,
  output logic [8:0] index_o
);
  // Clears the bits below the region size.
  function automatic logic [fph_pkg::ADDR_W-1:0] align(
    input logic [fph_pkg::ADDR_W-1:0] a, input int sh);
    return (a >> sh) << sh;
  endfunction

  // Chip erase has one region at address zero.
  always_comb begin
    case (kind_i)
      fph_pkg::ERASE_SECTOR: begin
        base_o = align(addr_i, fph_pkg::SECTOR_SHIFT); // RL18
        index_o = 9'(addr_i >> fph_pkg::SECTOR_SHIFT); // RL13
      end
      fph_pkg::ERASE_BLK32: begin
        base_o = align(addr_i, fph_pkg::BLK32_SHIFT); // RL18
        index_o = 9'(addr_i >> fph_pkg::BLK32_SHIFT); // RL12
      end
      fph_pkg::ERASE_BLK64: begin
        base_o = align(addr_i, fph_pkg::BLK64_SHIFT); // RL18
        index_o = 9'(addr_i >> fph_pkg::BLK64_SHIFT); // RL11
      end
      default: begin
        base_o = '0;
        index_o = 9'h000;
      end
    endcase
  end
endmodule

//--- rtl/fph_flash_front.sv
`timescale 1ns/1ps
// Contract
// RL1: protect pin is write-protect only for 0/0/1 setting
// RL2: protect low refuses status register writes
// RL3: quad enable makes protect pin quad lane two
// RL4: quad enable clear makes lane three hold
// RL5: quad enable set makes hold pin lane three
// RL6: hold pauses and keeps bit and byte position
// RL7: hold only while selected; ignored when deselected
// RL8: hold starts on falling hold, clock low
// RL9: hold ends on rising hold, clock low
// RL10: erase by sector, 32k, 64k block, chip
// RL11: D8h erases one of 32 aligned 64k blocks
// RL12: 52h erases one of 64 aligned 32k blocks
// RL13: 20h erases one of 512 4k sectors
// RL14: 256-byte pages; program writes 1 to 256 bytes
// RL15: chip select fall starts, rise ends operation
// RL16: sample on rising clock, drive on falling
// RL17: during hold outputs float, clock ignored
// RL18: erase ignores address bits below region size
module fph_flash_front (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CS_N_I,
  input wire logic SCK_I,
  input wire logic LANE0_I,
  output logic LANE0_O,
  output logic LANE0_OE_O,
  input wire logic LANE1_I,
  output logic LANE1_O,
  output logic LANE1_OE_O,
  input wire logic QUAD_LANE_TWO_I,
  output logic QUAD_LANE_TWO_O,
  output logic QUAD_LANE_TWO_OE_O,
  input wire logic QUAD_LANE_THREE_I,
  output logic QUAD_LANE_THREE_O,
  output logic QUAD_LANE_THREE_OE_O,
  input wire logic QUAD_LANE_ENABLE_I,
  input wire logic STATUS_PROTECT_UPPER_I,
  input wire logic STATUS_PROTECT_LOWER_I,
  output logic WRITE_PROTECT_ACTIVE_O,
  output logic STATUS_LOCKED_O,
  output logic HOLD_ACTIVE_O,
  output logic STATUS_WR_O,
  output logic STATUS_WR_REFUSED_O,
  output logic [7:0] STATUS_DATA_O,
  output logic ERASE_REQ_O,
  output fph_pkg::fph_erase_t ERASE_KIND_O,
  output logic [fph_pkg::ADDR_W-1:0] ERASE_ADDR_O,
  output logic [8:0] ERASE_INDEX_O,
  output logic PROG_WR_O,
  output logic [fph_pkg::ADDR_W-1:0] PROG_ADDR_O,
  output logic [7:0] PROG_DATA_O,
  output logic PROG_DONE_O,
  output logic [8:0] PROG_COUNT_O,
  output logic RD_REQ_O,
  output logic [fph_pkg::ADDR_W-1:0] RD_ADDR_O,
  input wire logic [7:0] RD_DATA_I
);
  logic [fph_pkg::SYNC_W-1:0] pins; // Filtered pin levels.
  logic cs_n; // Filtered chip select.
  logic sck; // Filtered serial clock.
  logic [3:0] lanes; // Filtered lanes, lane three in the top bit.
  logic sck_prev_ff; // Clock level one cycle back.
  logic cs_prev_ff; // Chip select level one cycle back.
  logic hold_prev_ff; // Lane three level one cycle back.
  logic hold_ff; // Transfer paused.
  fph_pkg::fph_state_t state_ff; // Frame phase.
  fph_pkg::fph_state_t nxt_state;
  logic [4:0] hdr_cnt_ff; // Header bit position.
  logic [7:0] opc_ff; // Captured opcode.
  logic [fph_pkg::ADDR_W-1:0] addr_ff; // Captured address, low bits.
  logic [7:0] byte_ff; // Data byte being assembled.
  logic [2:0] bit_cnt_ff; // Data bit position in the byte.
  logic any_data_ff; // At least one whole data byte arrived.
  logic [7:0] page_off_ff; // Program offset inside the page.
  logic [8:0] prog_cnt_ff; // Program bytes, saturating at a page.
  logic [7:0] dout_ff; // Read byte being shifted out.
  logic [2:0] obit_ff; // Read bit position.
  logic rd_load_ff; // Read data arrives this cycle.
  fph_pkg::fph_erase_t kind; // Granularity of the held opcode.
  logic [fph_pkg::ADDR_W-1:0] region_base;
  logic [8:0] region_index;
  logic sck_rise, sck_fall, cs_fall, cs_rise, hold_fall, hold_rise;
  logic rise_ok, fall_ok, quad_cmd, byte_done, reading, wp_mode;
  logic [2:0] step;
  logic [7:0] nxt_byte;

  // Host pins are filtered first.
  fph_pin_sync #(
    .W(fph_pkg::SYNC_W),
    .IDLE(fph_pkg::SYNC_IDLE)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .din_i({QUAD_LANE_THREE_I, QUAD_LANE_TWO_I, LANE1_I, LANE0_I,
            SCK_I, CS_N_I}),
    .dout_o(pins)
  );

  assign cs_n = pins[fph_pkg::SYNC_CS];
  assign sck = pins[fph_pkg::SYNC_SCK];
  assign lanes = pins[fph_pkg::SYNC_L0 +: 4];

  // Edges of filtered levels count once.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      sck_prev_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      hold_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck;
      cs_prev_ff <= cs_n;
      hold_prev_ff <= lanes[3];
    end
  end

  assign sck_rise = sck & ~sck_prev_ff;
  assign sck_fall = ~sck & sck_prev_ff;
  assign cs_fall = ~cs_n & cs_prev_ff;
  assign cs_rise = cs_n & ~cs_prev_ff;
  assign hold_fall = ~lanes[3] & hold_prev_ff;
  assign hold_rise = lanes[3] & ~hold_prev_ff;

  // Protect pin acts only in one setting.
  assign wp_mode = ~QUAD_LANE_ENABLE_I & ~STATUS_PROTECT_UPPER_I &
                   STATUS_PROTECT_LOWER_I; // RL1
  assign WRITE_PROTECT_ACTIVE_O = wp_mode;
  assign STATUS_LOCKED_O = wp_mode & ~lanes[2]; // RL2
  assign HOLD_ACTIVE_O = hold_ff;

  // Hold tracking; quad mode makes the pin a lane.
  // Hold edges with the clock high are ignored.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      hold_ff <= 1'b0;
    end else if (cs_n || QUAD_LANE_ENABLE_I) begin
      hold_ff <= 1'b0; // RL7 RL5
    end else if (!hold_ff && hold_fall && !sck) begin
      hold_ff <= 1'b1; // RL4 RL8
    end else if (hold_ff && hold_rise && !sck) begin
      hold_ff <= 1'b0; // RL9
    end
  end

  // Edges count only selected and unpaused; the rest
  // freezes, keeping the position through a hold.
  assign rise_ok = sck_rise & ~cs_n & ~hold_ff; // RL6 RL17 RL16
  assign fall_ok = sck_fall & ~cs_n & ~hold_ff; // RL6 RL17 RL16

  // Quad program takes four lanes per edge.
  assign quad_cmd = (opc_ff == fph_pkg::OP_QUAD_PROG); // RL3 RL5
  assign step = quad_cmd ? fph_pkg::STEP_QUAD : fph_pkg::STEP_SINGLE;
  assign byte_done = quad_cmd ? (bit_cnt_ff == fph_pkg::BIT_LAST_QUAD)
                              : (bit_cnt_ff == fph_pkg::BIT_LAST_SINGLE);
  assign nxt_byte = quad_cmd ? {byte_ff[3:0], lanes}
                             : {byte_ff[6:0], lanes[0]};
  assign reading = (state_ff == fph_pkg::ST_DATA) &&
                   (opc_ff == fph_pkg::OP_READ);
  assign kind = fph_pkg::erase_kind(opc_ff);

  // Next phase; unknown opcodes, or quad without quad mode,
  // skip until chip select rises.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fph_pkg::ST_IDLE: begin
        if (cs_fall) begin
          nxt_state = fph_pkg::ST_OPC; // RL15
        end
      end
      fph_pkg::ST_OPC: begin
        if (rise_ok && hdr_cnt_ff == fph_pkg::HDR_OPC_LAST) begin
          case ({opc_ff[6:0], lanes[0]})
            fph_pkg::OP_PAGE_PROG, fph_pkg::OP_READ,
            fph_pkg::OP_SECTOR_ERASE, fph_pkg::OP_BLK32_ERASE,
            fph_pkg::OP_BLK64_ERASE: begin
              nxt_state = fph_pkg::ST_ADDR;
            end
            fph_pkg::OP_QUAD_PROG: begin
              nxt_state = QUAD_LANE_ENABLE_I ? fph_pkg::ST_ADDR
                                             : fph_pkg::ST_SKIP; // RL3
            end
            fph_pkg::OP_WRITE_STATUS, fph_pkg::OP_CHIP_ERASE,
            fph_pkg::OP_CHIP_ERASE_ALT: begin
              nxt_state = fph_pkg::ST_DATA;
            end
            default: begin
              nxt_state = fph_pkg::ST_SKIP;
            end
          endcase
        end
      end
      fph_pkg::ST_ADDR: begin
        if (rise_ok && hdr_cnt_ff == fph_pkg::HDR_ADDR_LAST) begin
          nxt_state = fph_pkg::ST_DATA;
        end
      end
      default: begin
        nxt_state = state_ff;
      end
    endcase
    if (cs_rise) begin
      nxt_state = fph_pkg::ST_IDLE; // RL15
    end
  end

  // Phase register and header bit counter.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state_ff <= fph_pkg::ST_IDLE;
      hdr_cnt_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      if (cs_fall) begin
        hdr_cnt_ff <= 5'h00;
      end else if (rise_ok && (state_ff == fph_pkg::ST_OPC ||
                               state_ff == fph_pkg::ST_ADDR)) begin
        hdr_cnt_ff <= hdr_cnt_ff + 5'h01;
      end
    end
  end

  // Opcode and address shift in MSB first on lane zero; the
  // top three address bits fall off the register.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      opc_ff <= 8'h00;
      addr_ff <= '0;
    end else if (rise_ok && state_ff == fph_pkg::ST_OPC) begin
      opc_ff <= {opc_ff[6:0], lanes[0]}; // RL16
    end else if (rise_ok && state_ff == fph_pkg::ST_ADDR) begin
      addr_ff <= {addr_ff[fph_pkg::ADDR_W-2:0], lanes[0]}; // RL16
    end
  end

  // Data byte assembly for program and status writes.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      byte_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      any_data_ff <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_ff <= 3'h0;
      any_data_ff <= 1'b0;
    end else if (rise_ok && state_ff == fph_pkg::ST_DATA && !reading) begin
      byte_ff <= nxt_byte;
      bit_cnt_ff <= byte_done ? 3'h0 : bit_cnt_ff + step; // RL6
      if (byte_done) begin
        any_data_ff <= 1'b1;
      end
    end
  end

  // Program writes. The offset wraps inside the page, so a long burst
  // overwrites the page start; the count stops at one page.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      page_off_ff <= 8'h00;
      prog_cnt_ff <= 9'h000;
      PROG_WR_O <= 1'b0;
      PROG_ADDR_O <= '0;
      PROG_DATA_O <= 8'h00;
    end else begin
      PROG_WR_O <= 1'b0;
      if (rise_ok && state_ff == fph_pkg::ST_ADDR &&
          hdr_cnt_ff == fph_pkg::HDR_ADDR_LAST) begin
        page_off_ff <= {addr_ff[6:0], lanes[0]};
        prog_cnt_ff <= 9'h000;
      end else if (rise_ok && state_ff == fph_pkg::ST_DATA && byte_done &&
                   (opc_ff == fph_pkg::OP_PAGE_PROG || quad_cmd)) begin
        PROG_WR_O <= 1'b1;
        PROG_DATA_O <= nxt_byte;
        PROG_ADDR_O <= {addr_ff[fph_pkg::ADDR_W-1:fph_pkg::PAGE_SHIFT],
                        page_off_ff}; // RL14
        page_off_ff <= page_off_ff + 8'h01; // RL14
        if (prog_cnt_ff != fph_pkg::PAGE_BYTES) begin
          prog_cnt_ff <= prog_cnt_ff + 9'h001; // RL14
        end
      end
    end
  end

  // Read path: request after the address, shift out on falling
  // edges, request the next as the last bit leaves.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      RD_REQ_O <= 1'b0;
      RD_ADDR_O <= '0;
      rd_load_ff <= 1'b0;
      dout_ff <= 8'h00;
      obit_ff <= 3'h0;
      LANE1_O <= 1'b0;
    end else begin
      RD_REQ_O <= 1'b0;
      rd_load_ff <= RD_REQ_O;
      if (rise_ok && state_ff == fph_pkg::ST_ADDR &&
          hdr_cnt_ff == fph_pkg::HDR_ADDR_LAST &&
          opc_ff == fph_pkg::OP_READ) begin
        RD_REQ_O <= 1'b1;
        RD_ADDR_O <= {addr_ff[fph_pkg::ADDR_W-2:0], lanes[0]};
        obit_ff <= 3'h0;
      end else if (fall_ok && reading) begin
        LANE1_O <= dout_ff[7]; // RL16
        obit_ff <= obit_ff + 3'h1;
        if (obit_ff == fph_pkg::BIT_LAST_SINGLE) begin
          RD_REQ_O <= 1'b1;
          RD_ADDR_O <= RD_ADDR_O + 21'h000001;
        end
      end
      if (rd_load_ff) begin
        dout_ff <= RD_DATA_I;
      end else if (fall_ok && reading) begin
        dout_ff <= {dout_ff[6:0], 1'b0};
      end
    end
  end

  // Lane one drives only for read data, never in a hold;
  // the other lanes are inputs here.
  assign LANE1_OE_O = reading & ~cs_n & ~hold_ff; // RL17
  assign LANE0_O = 1'b0;
  assign LANE0_OE_O = 1'b0;
  assign QUAD_LANE_TWO_O = 1'b0;
  assign QUAD_LANE_TWO_OE_O = 1'b0;
  assign QUAD_LANE_THREE_O = 1'b0;
  assign QUAD_LANE_THREE_OE_O = 1'b0;

  fph_erase_map u_map (
    .kind_i(kind),
    .addr_i(addr_ff),
    .base_o(region_base),
    .index_o(region_index)
  );

  // End-of-frame actions. Erase acts only when the frame held exactly its
  // bits, a status write on one or more whole data bytes, so a short frame does nothing.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ERASE_REQ_O <= 1'b0;
      ERASE_KIND_O <= fph_pkg::ERASE_SECTOR;
      ERASE_ADDR_O <= '0;
      ERASE_INDEX_O <= 9'h000;
      STATUS_WR_O <= 1'b0;
      STATUS_WR_REFUSED_O <= 1'b0;
      STATUS_DATA_O <= 8'h00;
      PROG_DONE_O <= 1'b0;
      PROG_COUNT_O <= 9'h000;
    end else begin
      ERASE_REQ_O <= 1'b0;
      STATUS_WR_O <= 1'b0;
      STATUS_WR_REFUSED_O <= 1'b0;
      PROG_DONE_O <= 1'b0;
      if (cs_rise && state_ff == fph_pkg::ST_DATA) begin
        if (opc_ff == fph_pkg::OP_WRITE_STATUS) begin
          if (any_data_ff && bit_cnt_ff == 3'h0) begin
            STATUS_DATA_O <= byte_ff;
            STATUS_WR_O <= ~STATUS_LOCKED_O; // RL2
            STATUS_WR_REFUSED_O <= STATUS_LOCKED_O; // RL2
          end
        end else if (opc_ff == fph_pkg::OP_PAGE_PROG || quad_cmd) begin
          if (prog_cnt_ff != 9'h000) begin
            PROG_DONE_O <= 1'b1; // RL14
            PROG_COUNT_O <= prog_cnt_ff;
          end
        end else if (opc_ff != fph_pkg::OP_READ && !any_data_ff &&
                     bit_cnt_ff == 3'h0) begin
          ERASE_REQ_O <= 1'b1; // RL10
          ERASE_KIND_O <= kind; // RL10
          ERASE_ADDR_O <= region_base; // RL18
          ERASE_INDEX_O <= region_index; // RL11 RL12 RL13
        end
      end
    end
  end
endmodule

//--- verification/fph_checker.sv
`timescale 1ns/1ps
// Pin and flag checks, all on the system clock.
module fph_checker (
  input logic SYS_CLK_I,
  input logic RESET_I,
  input logic CS_N_I,
  input logic SCK_I,
  input logic QUAD_LANE_THREE_I,
  input logic QUAD_LANE_ENABLE_I,
  input logic STATUS_PROTECT_UPPER_I,
  input logic STATUS_PROTECT_LOWER_I,
  input logic WRITE_PROTECT_ACTIVE_O,
  input logic STATUS_LOCKED_O,
  input logic HOLD_ACTIVE_O,
  input logic STATUS_WR_REFUSED_O,
  input logic LANE1_OE_O,
  input logic ERASE_REQ_O,
  input fph_pkg::fph_erase_t ERASE_KIND_O,
  input logic [fph_pkg::ADDR_W-1:0] ERASE_ADDR_O,
  input logic [8:0] ERASE_INDEX_O,
  input logic PROG_DONE_O,
  input logic [8:0] PROG_COUNT_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  a_wp_decode: assert property (
    WRITE_PROTECT_ACTIVE_O == (!QUAD_LANE_ENABLE_I && !STATUS_PROTECT_UPPER_I
    && STATUS_PROTECT_LOWER_I)) else $error("protect decode");
  a_lock_needs_wp: assert property (
    STATUS_LOCKED_O |-> WRITE_PROTECT_ACTIVE_O) else $error("lock not in mode");
  a_refuse_locked: assert property (
    STATUS_WR_REFUSED_O |-> WRITE_PROTECT_ACTIVE_O) else $error("bad refusal");
  a_hold_gated: assert property (
    $rose(HOLD_ACTIVE_O) |-> !QUAD_LANE_ENABLE_I && !CS_N_I)
    else $error("hold while quad or idle");
  a_hold_start: assert property (
    $rose(HOLD_ACTIVE_O) |-> $past(!QUAD_LANE_THREE_I, 3) && !SCK_I)
    else $error("hold start wrong");
  a_hold_end: assert property (
    $fell(HOLD_ACTIVE_O) |-> QUAD_LANE_THREE_I && !SCK_I)
    else $error("hold end wrong");
  a_hold_float: assert property (
    HOLD_ACTIVE_O |-> !LANE1_OE_O) else $error("lane one driven in hold");
  a_idle_float: assert property (
    CS_N_I [*6] |=> !LANE1_OE_O) else $error("lane one driven idle");
  a_sector_align: assert property (
    ERASE_REQ_O && ERASE_KIND_O == fph_pkg::ERASE_SECTOR |->
    ERASE_ADDR_O[11:0] == 12'h000 && ERASE_INDEX_O == ERASE_ADDR_O[20:12])
    else $error("sector erase misaligned");
  a_blk64_align: assert property (
    ERASE_REQ_O && ERASE_KIND_O == fph_pkg::ERASE_BLK64 |->
    ERASE_ADDR_O[15:0] == 16'h0000
    && ERASE_INDEX_O == {4'h0, ERASE_ADDR_O[20:16]})
    else $error("block erase misaligned");
  a_erase_pulse: assert property (
    ERASE_REQ_O |=> !ERASE_REQ_O) else $error("erase pulse long");
  a_prog_count: assert property (
    PROG_DONE_O |-> PROG_COUNT_O != 9'h000
    && PROG_COUNT_O <= fph_pkg::PAGE_BYTES) else $error("count out of range");

  // Main scenarios.
  c_hold: cover property ($rose(HOLD_ACTIVE_O));
  c_erase: cover property (ERASE_REQ_O);
  c_refuse: cover property (STATUS_WR_REFUSED_O);
  c_prog: cover property (PROG_DONE_O);
endmodule

//--- verification/fph_host_model.sv
`timescale 1ns/1ps
// Host side of the link; lanes move only while the clock is low.
module fph_host_model (
  input wire logic clk_i,
  input wire logic lane1_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] lane_o
);
  logic wp_lvl = 1'b1; // Level put on the protect lane in single frames.
  logic [7:0] rx_byte = 8'h00; // Bits collected from lane one.

  // Idle: deselected, clock low, pulled-up lanes high.
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    lane_o = 4'hF;
  end

  // Half a 200 ns serial period, ending just after an edge.
  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // One serial clock; lane one is read late, as the reply lags the edge.
  task automatic clk(input logic [3:0] v);
    lane_o = v;
    half();
    sck_o = 1'b1;
    half();
    rx_byte = {rx_byte[6:0], lane1_i};
    sck_o = 1'b0;
  endtask

  // Sends the top n bits, MSB first.
  task automatic sbits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      clk({1'b1, wp_lvl, ~b[i], b[i]});
    end
  endtask

  // Chip select falls before the first clock.
  task automatic begin_f();
    cs_n_o = 1'b0;
    half();
  endtask

  // Chip select rises after the last clock; released lanes lose the bit.
  task automatic end_f();
    half();
    cs_n_o = 1'b1;
    lane_o = {1'b1, wp_lvl, ~lane_o[1:0]};
    repeat (3) half();
  endtask

  // Hold with the clock low, n ignored edges, release.
  task automatic hold(input int n);
    half();
    lane_o[3] = 1'b0;
    repeat (2) half();
    repeat (n) begin
      lane_o[0] = ~lane_o[0];
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
      half();
    end
    lane_o[3] = 1'b1;
    repeat (2) half();
  endtask
endmodule

//--- verification/test_fph_flash_front.sv
`timescale 1ns/1ps
// Drives the front end through the host model and judges each outcome.
module test_fph_flash_front;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic qe = 1'b0;
  logic upr = 1'b0;
  logic lwr = 1'b0;
  logic cs_n, sck, wpa, lck, hld, swr, sref, ereq, pwr, pdone, rreq;
  logic [3:0] hl, dout, doe, pin;
  logic [7:0] sdat, pdat, rdat, sd;
  logic [20:0] eaddr, paddr, raddr, ea, ra;
  logic [8:0] eidx, pcnt, ei, pc;
  fph_pkg::fph_erase_t ekind, ek;
  logic [5:0] ev = 6'h00; // Sticky: hold, read, done, erase, refuse, write.
  logic [20:0] pa[$];
  logic [7:0] pd[$];
  int bad_count = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;
  // Each pin merges the device's drive with the host's.
  assign pin = (doe & dout) | (~doe & hl);
  // Read data is a function of the address.
  assign rdat = raddr[7:0] ^ 8'h5A;

  // Collects pulses and the values that they qualify.
  always @(posedge clk) begin
    ev <= ev | {hld, rreq, pdone, ereq, sref, swr};
    if (swr) sd <= sdat;
    if (ereq) {ek, ea, ei} <= {ekind, eaddr, eidx};
    if (pdone) pc <= pcnt;
    if (rreq) ra <= raddr;
    if (pwr) pa.push_back(paddr);
    if (pwr) pd.push_back(pdat);
  end

  fph_host_model u_host (.clk_i(clk), .lane1_i(pin[1]), .cs_n_o(cs_n),
    .sck_o(sck), .lane_o(hl));
  fph_flash_front u_dut (.SYS_CLK_I(clk), .RESET_I(rst), .CS_N_I(cs_n),
    .SCK_I(sck), .LANE0_I(pin[0]), .LANE0_O(dout[0]), .LANE0_OE_O(doe[0]),
    .LANE1_I(pin[1]), .LANE1_O(dout[1]), .LANE1_OE_O(doe[1]),
    .QUAD_LANE_TWO_I(pin[2]), .QUAD_LANE_TWO_O(dout[2]),
    .QUAD_LANE_TWO_OE_O(doe[2]), .QUAD_LANE_THREE_I(pin[3]),
    .QUAD_LANE_THREE_O(dout[3]), .QUAD_LANE_THREE_OE_O(doe[3]),
    .QUAD_LANE_ENABLE_I(qe), .STATUS_PROTECT_UPPER_I(upr),
    .STATUS_PROTECT_LOWER_I(lwr), .WRITE_PROTECT_ACTIVE_O(wpa),
    .STATUS_LOCKED_O(lck), .HOLD_ACTIVE_O(hld), .STATUS_WR_O(swr),
    .STATUS_WR_REFUSED_O(sref), .STATUS_DATA_O(sdat), .ERASE_REQ_O(ereq),
    .ERASE_KIND_O(ekind), .ERASE_ADDR_O(eaddr), .ERASE_INDEX_O(eidx),
    .PROG_WR_O(pwr), .PROG_ADDR_O(paddr), .PROG_DATA_O(pdat),
    .PROG_DONE_O(pdone), .PROG_COUNT_O(pcnt), .RD_REQ_O(rreq),
    .RD_ADDR_O(raddr), .RD_DATA_I(rdat));

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for any flag of a mask; a miss ends the run.
  task automatic await(input logic [5:0] m);
    for (int n = 0; n < 80 && (ev & m) == 6'h00; n++) @(posedge clk);
    chk("event flag", 32'h1, {31'h0, |(ev & m)});
    if ((ev & m) == 6'h00) test_done();
  endtask

  // Opens a frame with an opcode and na address bytes.
  task automatic head(input logic [7:0] op, input logic [23:0] a,
    input int na);
    ev = 6'h00;
    u_host.begin_f();
    u_host.sbits(op, 8);
    for (int i = na - 1; i >= 0; i--) u_host.sbits(a[8*i+:8], 8);
  endtask

  // All eight settings of the three mode bits.
  task automatic t_pins();
    for (int i = 0; i < 8; i++) begin
      {qe, upr, lwr} = i[2:0];
      @(posedge clk);
      #1;
      chk("protect mode", {31'h0, i == 1}, {31'h0, wpa});
    end
  endtask

  // A status write with the protect lane at wp; rf says if refused.
  task automatic t_status(input logic q, input logic wp, input logic rf);
    {qe, upr, lwr} = {q, 2'b01};
    u_host.wp_lvl = wp;
    head(8'h01, 24'hA5A5A5, 1);
    u_host.end_f();
    await(6'h03);
    chk("status refused", {31'h0, rf}, {31'h0, ev[1]});
    chk("status written", {31'h0, ~rf}, {31'h0, ev[0]});
    if (!rf) chk("status data", 32'hA5, {24'h0, sd});
    u_host.wp_lvl = 1'b1;
  endtask

  task automatic t_erase(input logic [7:0] op, input logic [23:0] a,
    input fph_pkg::fph_erase_t k, input logic [20:0] b, input logic [8:0] x);
    head(op, a, (k == fph_pkg::ERASE_CHIP) ? 0 : 3);
    u_host.end_f();
    await(6'h04);
    chk("erase kind", {30'h0, k}, {30'h0, ek});
    chk("erase base", {11'h0, b}, {11'h0, ea});
    chk("erase index", {23'h0, x}, {23'h0, ei});
  endtask

  // Three bytes wrapping at a page end, paused mid-byte with stray edges.
  task automatic t_prog();
    logic [20:0] ex[3] = '{21'h0001FE, 21'h0001FF, 21'h000100};
    logic [7:0] dx[3] = '{8'h3C, 8'hC3, 8'h5A};
    pa.delete();
    pd.delete();
    head(fph_pkg::OP_PAGE_PROG, 24'h0001FE, 3);
    u_host.sbits(8'h3C, 8);
    u_host.sbits(8'hC3, 4);
    u_host.hold(2);
    chk("hold seen", 32'h1, {31'h0, ev[5]});
    u_host.sbits(8'h30, 4);
    u_host.sbits(8'h5A, 8);
    u_host.end_f();
    await(6'h08);
    chk("program count", 32'h3, {23'h0, pc});
    for (int i = 0; i < 3; i++) begin
      chk("program address", {11'h0, ex[i]}, {11'h0, pa[i]});
      chk("program data", {24'h0, dx[i]}, {24'h0, pd[i]});
    end
  endtask

  // Quad byte over all lanes, then a hold while deselected.
  task automatic t_quad();
    pa.delete();
    pd.delete();
    qe = 1'b1;
    head(fph_pkg::OP_QUAD_PROG, 24'hFFFFFF, 3);
    u_host.clk(4'hA);
    u_host.clk(4'h5);
    u_host.end_f();
    await(6'h08);
    chk("quad data", 32'hA5, {24'h0, pd[0]});
    chk("quad address", 32'h1FFFFF, {11'h0, pa[0]});
    qe = 1'b0;
    u_host.hold(0);
    chk("hold ignored", 32'h0, {31'h0, ev[5]});
  endtask

  task automatic t_read();
    head(fph_pkg::OP_READ, 24'h000010, 3);
    u_host.sbits(8'h00, 8);
    chk("read byte", 32'h4A, {24'h0, u_host.rx_byte});
    chk("lane one drive", 32'h1, {31'h0, doe[1]});
    u_host.end_f();
    chk("next read address", 32'h11, {11'h0, ra});
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_pins();
    t_status(1'b1, 1'b0, 1'b0);
    t_status(1'b0, 1'b1, 1'b0);
    t_status(1'b0, 1'b0, 1'b1);
    t_erase(8'h20, 24'hFFF123, fph_pkg::ERASE_SECTOR, 21'h1FF000, 9'h1FF);
    t_erase(8'h52, 24'h00ABCD, fph_pkg::ERASE_BLK32, 21'h008000, 9'h001);
    t_erase(8'hD8, 24'h1F0001, fph_pkg::ERASE_BLK64, 21'h1F0000, 9'h01F);
    t_erase(8'hC7, 24'h000000, fph_pkg::ERASE_CHIP, 21'h000000, 9'h000);
    t_erase(8'h60, 24'h000000, fph_pkg::ERASE_CHIP, 21'h000000, 9'h000);
    t_prog();
    t_read();
    t_quad();
    test_done();
  end
endmodule

bind fph_flash_front fph_checker u_chk (.*);
